// file: design/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r <= '0;
			q_out  <= '0;
		end else begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule
`default_nettype wire

// file: design/usb_port_iso_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "usb_port_map_params.svh"
module usb_port_iso_regs
	import usb_port_map_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        power_control_cap_in,
	input  wire logic        indicator_cap_in,
	input  wire logic        bus_cs_in,
	input  wire logic        bus_wr_in,
	input  wire logic        bus_rd_in,
	input  wire logic [8:0]  bus_addr_in,
	input  wire logic [31:0] bus_wdata_in,
	output logic      [31:0] bus_rdata_out,
	input  wire logic        line_dp_in,
	input  wire logic        line_dm_in,
	input  wire logic        device_attached_in,
	input  wire logic        resume_k_detect_in,
	input  wire logic        port_reset_done_in,
	input  wire logic [31:0] iso_done_set_in,
	output logic      [31:0] iso_skip_out,
	output logic             routing_config_out,
	output logic      [3:0]  port_test_sel_out,
	output logic      [1:0]  port_indicator_out,
	output logic             port_owner_out,
	output logic             port_power_out,
	output logic             port_reset_out,
	output logic             port_suspend_out,
	output logic             port_enable_out
);
	logic        cfg_flag_r;
	logic        cfg_flag_d_r;
	port_ctl_t   port_r;
	logic        connect_r;
	logic [31:0] iso_done_r;
	logic [31:0] iso_skip_r;
	logic [1:0]  line_s;
	logic        attach_s;
	logic        kdet_s;
	logic        wr_cfg;
	logic        wr_port;
	logic        wr_skip;
	logic        rd_done;
	logic        can_change;
	logic [31:0] port_view;
	logic [31:0] rdata_nxt;
	port_state_t pstate;

	sync2 #(.W(4)) u_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   ({line_dp_in, line_dm_in, device_attached_in, resume_k_detect_in}),
		.q_out  ({line_s, attach_s, kdet_s})
	);

	assign wr_cfg  = bus_cs_in && bus_wr_in && (bus_addr_in == `CFG_DONE_OFFSET);
	assign wr_port = bus_cs_in && bus_wr_in && (bus_addr_in == `PORT1_SC_OFFSET);
	assign wr_skip = bus_cs_in && bus_wr_in && (bus_addr_in == `ISO_SKIP_OFFSET);
	assign rd_done = bus_cs_in && bus_rd_in && (bus_addr_in == `ISO_DONE_OFFSET);
	// Without power control the port is always powered, so state may change freely
	assign can_change = !power_control_cap_in || port_r.power;

	always_comb begin
		if (!port_r.power)
			pstate = PORT_OFF;
		else if (port_r.enabled)
			pstate = PORT_ACTIVE;
		else
			pstate = PORT_IDLE;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_flag_r   <= 1'b0;
			cfg_flag_d_r <= 1'b0;
		end else begin
			if (wr_cfg)
				cfg_flag_r <= bus_wdata_in[`CFG_FLAG_BIT];
			cfg_flag_d_r <= cfg_flag_r;
		end
	end

	// The controller reset loads the port defaults; software writes to the port register and the configure flag also update it
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			port_r    <= '{test_sel: 4'h0, indicator: 2'h0, owner: 1'b1, power: 1'b0,
				reset_act: 1'b0, sleeping: 1'b0, resume: 1'b0, enabled: 1'b0, change: 1'b0};
			connect_r <= 1'b0;
		end else begin
			connect_r <= attach_s;
			if (!cfg_flag_r)
				port_r.owner <= 1'b1;
			else if (!cfg_flag_d_r)
				port_r.owner <= 1'b0;
			else if (wr_port)
				port_r.owner <= bus_wdata_in[`OWNER_BIT];
			if (!power_control_cap_in)
				port_r.power <= 1'b1;
			else if (wr_port)
				port_r.power <= bus_wdata_in[`POWER_BIT];
			if (wr_port && indicator_cap_in)
				port_r.indicator <= bus_wdata_in[`PIC_MSB:`PIC_LSB];
			if (wr_port && can_change)
				port_r.test_sel <= bus_wdata_in[`PTC_MSB:`PTC_LSB];
			if (wr_port && can_change && bus_wdata_in[`RESET_BIT])
				port_r.reset_act <= 1'b1;
			else if (port_reset_done_in)
				port_r.reset_act <= 1'b0;
			// A disabled port cannot stay suspended, so a detach also ends suspend
			if (!port_r.enabled)
				port_r.sleeping <= 1'b0;
			else if (wr_port && can_change)
				port_r.sleeping <= bus_wdata_in[`PORT_SLEEPING_BIT];
			if (kdet_s)
				port_r.resume <= 1'b1;
			else if (wr_port && can_change)
				port_r.resume <= bus_wdata_in[`RESUME_BIT];
			if (!attach_s)
				port_r.enabled <= 1'b0;
			else if (port_r.reset_act && port_reset_done_in)
				port_r.enabled <= 1'b1;
			else if (wr_port && can_change && !bus_wdata_in[`ENABLE_BIT])
				port_r.enabled <= 1'b0;
			// A connect edge wins over a write-one clear in the same cycle
			if (attach_s != connect_r)
				port_r.change <= 1'b1;
			else if (wr_port && can_change && bus_wdata_in[`CHANGE_BIT])
				port_r.change <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			iso_done_r <= `ISO_DONE_RESET;
		end else if (rd_done) begin
			iso_done_r <= iso_done_set_in;
		end else begin
			iso_done_r <= iso_done_r | iso_done_set_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			iso_skip_r <= `ISO_SKIP_RESET;
		else if (wr_skip)
			iso_skip_r <= bus_wdata_in;
	end

	always_comb begin
		port_view = 32'h0000_0000;
		port_view[`PTC_MSB:`PTC_LSB] = port_r.test_sel;
		port_view[`PIC_MSB:`PIC_LSB] = port_r.indicator;
		port_view[`OWNER_BIT]   = port_r.owner;
		port_view[`POWER_BIT]   = port_r.power;
		port_view[`LINE_DP_BIT] = line_s[1];
		port_view[`LINE_DM_BIT] = line_s[0];
		if (port_r.power) begin
			port_view[`RESET_BIT]   = port_r.reset_act;
			port_view[`PORT_SLEEPING_BIT]    = port_r.sleeping;
			port_view[`RESUME_BIT]  = port_r.resume;
			port_view[`ENABLE_BIT]  = port_r.enabled;
			port_view[`CHANGE_BIT]  = port_r.change;
			port_view[`CONNECT_BIT] = connect_r;
		end
		rdata_nxt = 32'h0000_0000;
		if (bus_cs_in && bus_rd_in) begin
			case (bus_addr_in)
				`CFG_DONE_OFFSET: rdata_nxt = {31'h0, cfg_flag_r};
				`PORT1_SC_OFFSET: rdata_nxt = port_view;
				`ISO_DONE_OFFSET: rdata_nxt = iso_done_r;
				`ISO_SKIP_OFFSET: rdata_nxt = iso_skip_r;
				default:          rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bus_rdata_out      <= 32'h0000_0000;
			iso_skip_out       <= `ISO_SKIP_RESET;
			routing_config_out <= 1'b0;
			port_test_sel_out  <= 4'h0;
			port_indicator_out <= 2'h0;
			port_owner_out     <= 1'b1;
			port_power_out     <= 1'b0;
			port_reset_out     <= 1'b0;
			port_suspend_out   <= 1'b0;
			port_enable_out    <= 1'b0;
		end else begin
			bus_rdata_out      <= rdata_nxt;
			iso_skip_out       <= iso_skip_r;
			routing_config_out <= cfg_flag_r;
			port_test_sel_out  <= port_r.test_sel;
			port_indicator_out <= port_r.indicator;
			port_owner_out     <= port_r.owner;
			port_power_out     <= port_r.power;
			port_reset_out     <= port_r.reset_act && (pstate != PORT_OFF);
			port_suspend_out   <= port_r.sleeping && (pstate == PORT_ACTIVE);
			port_enable_out    <= (pstate == PORT_ACTIVE);
		end
	end

	property p_owner_forced;
		@(posedge clk_in) disable iff (rst_in) !cfg_flag_r |=> port_r.owner;
	endproperty
	a_owner_forced: assert property (p_owner_forced) else $error("owner not forced high");
	property p_owner_rise;
		@(posedge clk_in) disable iff (rst_in) (cfg_flag_r && !cfg_flag_d_r) |=> !port_r.owner;
	endproperty
	a_owner_rise: assert property (p_owner_rise) else $error("owner not cleared on flag rise");
	property p_routing;
		@(posedge clk_in) disable iff (rst_in) 1'b1 |=> routing_config_out == $past(cfg_flag_r);
	endproperty
	a_routing: assert property (p_routing) else $error("routing output wrong");
	// Checked at the bus output so the masking is seen as software sees it
	property p_unpowered_zero;
		@(posedge clk_in) disable iff (rst_in)
			(bus_cs_in && bus_rd_in && (bus_addr_in == `PORT1_SC_OFFSET) && !port_r.power)
			|=> (bus_rdata_out & 32'h0000_01c7) == 32'h0000_0000;
	endproperty
	a_unpowered_zero: assert property (p_unpowered_zero) else $error("status visible without power");
	property p_blocked;
		@(posedge clk_in) disable iff (rst_in)
			(wr_port && power_control_cap_in && !port_r.power) |=> $stable(port_r.test_sel);
	endproperty
	a_blocked: assert property (p_blocked) else $error("write took effect unpowered");
	property p_indicator;
		@(posedge clk_in) disable iff (rst_in) !indicator_cap_in |=> $stable(port_r.indicator);
	endproperty
	a_indicator: assert property (p_indicator) else $error("indicator changed without capability");
	property p_done_keep;
		@(posedge clk_in) disable iff (rst_in) rd_done |=> iso_done_r == $past(iso_done_set_in);
	endproperty
	a_done_keep: assert property (p_done_keep) else $error("read clear lost a completion");
	property p_done_set;
		@(posedge clk_in) disable iff (rst_in) !rd_done |=> (iso_done_r & $past(iso_done_set_in)) == $past(iso_done_set_in);
	endproperty
	a_done_set: assert property (p_done_set) else $error("completion bit not set");
	property p_change;
		@(posedge clk_in) disable iff (rst_in) (attach_s != connect_r) |=> port_r.change;
	endproperty
	a_change: assert property (p_change) else $error("connect change missed");

	// Power and port control fields
	property p_power_forced;
		@(posedge clk_in) disable iff (rst_in) !power_control_cap_in |=> port_r.power;
	endproperty
	a_power_forced: assert property (p_power_forced) else $error("power not forced without control");
	property p_unpowered_out;
		@(posedge clk_in) disable iff (rst_in)
			!port_r.power |=> !port_reset_out && !port_suspend_out && !port_enable_out;
	endproperty
	a_unpowered_out: assert property (p_unpowered_out) else $error("port output active without power");
	property p_test_write;
		@(posedge clk_in) disable iff (rst_in)
			(wr_port && can_change) |=> port_r.test_sel == $past(bus_wdata_in[`PTC_MSB:`PTC_LSB]);
	endproperty
	a_test_write: assert property (p_test_write) else $error("test select write lost");
	property p_test_out;
		@(posedge clk_in) disable iff (rst_in) 1'b1 |=> port_test_sel_out == $past(port_r.test_sel);
	endproperty
	a_test_out: assert property (p_test_out) else $error("test select output wrong");
	property p_indicator_out;
		@(posedge clk_in) disable iff (rst_in) 1'b1 |=> port_indicator_out == $past(port_r.indicator);
	endproperty
	a_indicator_out: assert property (p_indicator_out) else $error("indicator output wrong");

	// Reset, suspend, resume and enable
	property p_reset_start;
		@(posedge clk_in) disable iff (rst_in)
			(wr_port && can_change && bus_wdata_in[`RESET_BIT]) |=> port_r.reset_act;
	endproperty
	a_reset_start: assert property (p_reset_start) else $error("port reset not started");
	property p_reset_end;
		@(posedge clk_in) disable iff (rst_in)
			(port_reset_done_in && !(wr_port && can_change && bus_wdata_in[`RESET_BIT])) |=> !port_r.reset_act;
	endproperty
	a_reset_end: assert property (p_reset_end) else $error("port reset not ended");
	property p_sleep_enable;
		@(posedge clk_in) disable iff (rst_in) !port_r.enabled |=> !port_r.sleeping;
	endproperty
	a_sleep_enable: assert property (p_sleep_enable) else $error("disabled port left suspended");
	property p_resume_k;
		@(posedge clk_in) disable iff (rst_in) kdet_s |=> port_r.resume;
	endproperty
	a_resume_k: assert property (p_resume_k) else $error("resume state not flagged");
	property p_enable_drop;
		@(posedge clk_in) disable iff (rst_in) !attach_s |=> !port_r.enabled;
	endproperty
	a_enable_drop: assert property (p_enable_drop) else $error("port enabled with no device");
	property p_enable_by_reset;
		@(posedge clk_in) disable iff (rst_in) $rose(port_r.enabled) |-> $past(port_r.reset_act && port_reset_done_in);
	endproperty
	a_enable_by_reset: assert property (p_enable_by_reset) else $error("port enabled without reset");
	property p_enable_out;
		@(posedge clk_in) disable iff (rst_in) 1'b1 |=> port_enable_out == $past(port_r.power && port_r.enabled);
	endproperty
	a_enable_out: assert property (p_enable_out) else $error("enable output wrong");

	// Line levels, connect status and the maps
	property p_line_read;
		@(posedge clk_in) disable iff (rst_in) (bus_cs_in && bus_rd_in && (bus_addr_in == `PORT1_SC_OFFSET))
			|=> bus_rdata_out[`LINE_DP_BIT:`LINE_DM_BIT] == $past(line_s);
	endproperty
	a_line_read: assert property (p_line_read) else $error("line levels read wrong");
	property p_connect_follow;
		@(posedge clk_in) disable iff (rst_in) 1'b1 |=> connect_r == $past(attach_s);
	endproperty
	a_connect_follow: assert property (p_connect_follow) else $error("connect status stale");
	property p_done_read;
		@(posedge clk_in) disable iff (rst_in) rd_done |=> bus_rdata_out == $past(iso_done_r);
	endproperty
	a_done_read: assert property (p_done_read) else $error("completion map read wrong");
	property p_skip_write;
		@(posedge clk_in) disable iff (rst_in) wr_skip |=> iso_skip_r == $past(bus_wdata_in);
	endproperty
	a_skip_write: assert property (p_skip_write) else $error("skip map write lost");

	c_rise: cover property (@(posedge clk_in) disable iff (rst_in) cfg_flag_r && !cfg_flag_d_r);
	c_read_clear: cover property (@(posedge clk_in) disable iff (rst_in) rd_done && iso_done_r != 32'h0);
	c_enable: cover property (@(posedge clk_in) disable iff (rst_in) pstate == PORT_ACTIVE);
	c_test_mode: cover property (@(posedge clk_in) disable iff (rst_in) port_r.test_sel != 4'h0);
	c_reset_done: cover property (@(posedge clk_in) disable iff (rst_in) port_r.reset_act && port_reset_done_in);
endmodule
`default_nettype wire

// file: design/usb_port_map_params.svh
`ifndef USB_PORT_MAP_PARAMS_SVH
`define USB_PORT_MAP_PARAMS_SVH
`define CFG_DONE_OFFSET      9'h060
`define PORT1_SC_OFFSET      9'h064
`define ISO_DONE_OFFSET      9'h130
`define ISO_SKIP_OFFSET      9'h134
`define CFG_FLAG_BIT         0
`define PTC_LSB              16
`define PTC_MSB              19
`define PIC_LSB              14
`define PIC_MSB              15
`define OWNER_BIT            13
`define POWER_BIT            12
`define LINE_DP_BIT          11
`define LINE_DM_BIT          10
`define RESET_BIT            8
`define PORT_SLEEPING_BIT             7
`define RESUME_BIT           6
`define ENABLE_BIT           2
`define CHANGE_BIT           1
`define CONNECT_BIT          0
`define ISO_DONE_RESET       32'h0000_0000
`define ISO_SKIP_RESET       32'hffff_ffff
`define POWER_STABLE_MS      20
`define CLK_MHZ              100
`define POWER_STABLE_CYCLES  (`POWER_STABLE_MS * 1000 * `CLK_MHZ)
`endif

// file: design/usb_port_map_pkg.sv
package usb_port_map_pkg;
	typedef struct packed {
		logic [3:0] test_sel;
		logic [1:0] indicator;
		logic       owner;
		logic       power;
		logic       reset_act;
		logic       sleeping;
		logic       resume;
		logic       enabled;
		logic       change;
	} port_ctl_t;
	typedef enum logic [1:0] {
		PORT_OFF     = 2'b00,
		PORT_IDLE    = 2'b01,
		PORT_ACTIVE  = 2'b11
	} port_state_t;
endpackage

// file: tb/usb_port_iso_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module usb_port_iso_regs_tb_top;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        pcap, icap, cs, wr, rd, attach, k_drv;
	logic [8:0]  addr;
	logic [31:0] wdata, done_set, rdata, skip, d;
	logic        dp, dm, att, kdet, rdone, cfg, owner, pwr, prst, port_sleeping, pen;
	logic [3:0]  tsel;
	logic [1:0]  ind;
	int          errors = 0;
	int          compares = 0;
	always #5 clk_in = ~clk_in;
	usb_port_iso_regs dut_u (.clk_in(clk_in), .rst_in(rst_in), .power_control_cap_in(pcap),
		.indicator_cap_in(icap), .bus_cs_in(cs), .bus_wr_in(wr), .bus_rd_in(rd), .bus_addr_in(addr),
		.bus_wdata_in(wdata), .bus_rdata_out(rdata), .line_dp_in(dp), .line_dm_in(dm),
		.device_attached_in(att), .resume_k_detect_in(kdet), .port_reset_done_in(rdone),
		.iso_done_set_in(done_set), .iso_skip_out(skip), .routing_config_out(cfg),
		.port_test_sel_out(tsel), .port_indicator_out(ind), .port_owner_out(owner),
		.port_power_out(pwr), .port_reset_out(prst), .port_suspend_out(port_sleeping), .port_enable_out(pen));
	usb_port_model port_u (.clk_in(clk_in), .rst_in(rst_in), .attach_in(attach), .k_in(k_drv),
		.port_reset_in(prst), .line_dp_out(dp), .line_dm_out(dm), .attached_out(att),
		.k_detect_out(kdet), .reset_done_out(rdone));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic close_out;
		$display("Comparisons %0d, errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic wr_reg(input logic [8:0] a, input logic [31:0] v);
		@(posedge clk_in);
		#1;
		{cs, wr, addr, wdata} = {2'b11, a, v};
		cyc(1);
		{cs, wr} = 2'b00;
	endtask
	// Read data stands only in the cycle after the taking edge, so it is caught there
	task automatic rd_reg(input logic [8:0] a, input logic [31:0] s, output logic [31:0] v);
		@(posedge clk_in);
		#1;
		{cs, rd, addr, done_set} = {2'b11, a, s};
		cyc(1);
		v = rdata;
		{cs, rd, done_set} = {2'b00, 32'h0};
	endtask
	initial begin
		{pcap, icap, cs, wr, rd, attach, k_drv} = 7'b1000000;
		{addr, wdata, done_set} = '0;
		cyc(2);
		rst_in = 1'b0;
		rd_reg(9'h130, 32'h0, d); `CHK("done_map", 32'h0, d)
		rd_reg(9'h134, 32'h0, d); `CHK("skip_map", 32'hffff_ffff, d)
		rd_reg(9'h060, 32'h0, d); `CHK("cfg", 32'h0, d)
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_2000, d)
		rd_reg(9'h100, 32'h5, d); `CHK("unmapped", 32'h0, d)
		rd_reg(9'h130, 32'h0, d); `CHK("done_map", 32'h5, d)
		rd_reg(9'h130, 32'h8000_0000, d); `CHK("done_map", 32'h0, d)
		rd_reg(9'h130, 32'h0, d); `CHK("done_map", 32'h8000_0000, d)
		// Skipped slots kept clear of any slot a live link points at
		wr_reg(9'h134, 32'h0000_00f0);
		rd_reg(9'h134, 32'h0, d); `CHK("skip_map", 32'h0000_00f0, d)
		`CHK("skip_out", 32'h0000_00f0, skip)
		attach = 1'b1;
		wr_reg(9'h064, 32'h0000_0100);
		cyc(6);
		`CHK("reset_out", 1'b0, prst)
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_2800, d)
		wr_reg(9'h060, 32'h1);
		cyc(3);
		`CHK("routing", 1'b1, cfg)
		`CHK("owner", 1'b0, owner)
		// The model's supply settles at once, so the settling wait is kept short
		wr_reg(9'h064, 32'h0000_1000);
		cyc(6);
		`CHK("power_out", 1'b1, pwr)
		wr_reg(9'h064, 32'h0000_1002);
		attach = 1'b0;
		cyc(6);
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_1002, d)
		attach = 1'b1;
		cyc(6);
		wr_reg(9'h064, 32'h0000_1002);
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_1801, d)
		wr_reg(9'h064, 32'h0000_1100);
		rd_reg(9'h064, 32'h0, d); `CHK("in_reset", 2'b10, {d[8], d[2]})
		`CHK("reset_out", 1'b1, prst)
		for (int i = 0; i < 50 && pen !== 1'b1; i++) cyc(1);
		`CHK("enable_out", 1'b1, pen)
		if (pen !== 1'b1) close_out();
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_1805, d)
		wr_reg(9'h064, 32'h0000_1084);
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_1885, d)
		`CHK("suspend_out", 1'b1, port_sleeping)
		k_drv = 1'b1;
		cyc(6);
		rd_reg(9'h064, 32'h0, d); `CHK("resume_ls", 3'b101, {d[6], d[11:10]})
		k_drv = 1'b0;
		wr_reg(9'h064, 32'h0004_1004);
		cyc(2);
		`CHK("test_sel", 4'h4, tsel)
		wr_reg(9'h064, 32'h0000_d004);
		cyc(2);
		`CHK("test_sel", 4'h0, tsel)
		`CHK("indicator", 2'b00, ind)
		icap = 1'b1;
		wr_reg(9'h064, 32'h0000_d004);
		cyc(2);
		`CHK("indicator", 2'b11, ind)
		wr_reg(9'h064, 32'h0000_1000);
		cyc(2);
		`CHK("enable_out", 1'b0, pen)
		wr_reg(9'h064, 32'h0);
		cyc(6);
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_0800, d)
		pcap = 1'b0;
		cyc(3);
		rd_reg(9'h064, 32'h0, d); `CHK("forced_power", 1'b1, d[12])
		pcap = 1'b1;
		rst_in = 1'b1;
		cyc(2);
		rst_in = 1'b0;
		// The line synchroniser restarts from zero, so let the levels pass it again
		cyc(3);
		rd_reg(9'h064, 32'h0, d); `CHK("port1", 32'h0000_2800, d)
		rd_reg(9'h060, 32'h0, d); `CHK("cfg", 32'h0, d)
		`CHK("skip_out", 32'hffff_ffff, skip)
		close_out();
	end
endmodule
`default_nettype wire

// file: tb/usb_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module usb_port_model (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic attach_in,
	input  wire logic k_in,
	input  wire logic port_reset_in,
	output logic      line_dp_out,
	output logic      line_dm_out,
	output logic      attached_out,
	output logic      k_detect_out,
	output var logic  reset_done_out
);
	logic [3:0] rst_cnt_r;
	// Detached lines sit at SE0 through the host pull-downs; K is the resume state
	assign line_dp_out  = attach_in & ~k_in;
	assign line_dm_out  = attach_in & k_in;
	assign attached_out = attach_in;
	assign k_detect_out = attach_in & k_in;
	// Reset signalling lasts a fixed stretch, then completion pulses for one cycle, again every 16 cycles while reset is held
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_cnt_r      <= 4'h0;
			reset_done_out <= 1'b0;
		end else begin
			rst_cnt_r      <= port_reset_in ? rst_cnt_r + 4'h1 : 4'h0;
			reset_done_out <= port_reset_in && (rst_cnt_r == 4'h7);
		end
	end
endmodule
`default_nettype wire
